// ### edge_event_pkg.sv
// constants for the edge event request unit
package edge_event_pkg;
  // =========================================================
  // line layout
  localparam int LINE_COUNT = 18;
  localparam int EXT_LINES  = 16;
  localparam int INT_LINES  = LINE_COUNT - EXT_LINES;
  localparam int SEL_W      = 7;
  localparam int SEL_SLOT   = 8;
  localparam int SEL_PER_REG = 4;
  localparam int SEL_REGS   = EXT_LINES / SEL_PER_REG;

  // =========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_INT_MASK = 8'h00;
  localparam logic [7:0] OFS_EVT_MASK = 8'h04;
  localparam logic [7:0] OFS_RISE_EN  = 8'h08;
  localparam logic [7:0] OFS_FALL_EN  = 8'h0c;
  localparam logic [7:0] OFS_SW_TRIG  = 8'h10;
  localparam logic [7:0] OFS_PENDING  = 8'h14;
  localparam logic [7:0] OFS_SEL0     = 8'h18;
  localparam logic [7:0] OFS_SEL3     = 8'h24;

  // =========================================================
  // reset values
  localparam logic [LINE_COUNT-1:0] RST_MASK = 18'h00000;
  localparam logic [LINE_COUNT-1:0] RST_EDGE = 18'h00000;
  localparam logic [SEL_W-1:0]      RST_SEL  = 7'h00;
endpackage

// ### edge_event_request_unit.sv
// edge event request unit: edge detection, masking, pending and apb registers
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns

// What this block does
// - eighteen edge lines each raise an interrupt request or an event request on their edge.
// - each line selects rising edges, falling edges or both.
// - each line has its own interrupt mask and event mask; a line masked in both forwards no request.
// - each line keeps a pending bit recording that its edge or a software trigger raised an interrupt request.
// - pulses as narrow as one sample are still caught as edges.
// - a selector lets any of up to 128 pins drive each of the sixteen external lines.
module edge_event_request_unit #(
  parameter int PIN_COUNT = 112,
  parameter int ADDR_W    = 8
) (
  input  wire logic                                 clock,
  input  wire logic                                 rst,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [ADDR_W-1:0]                    paddr,
  input  wire logic [31:0]                          pwdata,
  output logic      [31:0]                          prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire logic [PIN_COUNT-1:0]                 gpio_in,
  input  wire logic [edge_event_pkg::INT_LINES-1:0] int_src,
  output logic      [edge_event_pkg::LINE_COUNT-1:0] line_irq,
  output logic      [edge_event_pkg::LINE_COUNT-1:0] line_event,
  output logic                                      irq
);
  localparam int N = edge_event_pkg::LINE_COUNT;

  // =========================================================
  // elaboration checks
  if (PIN_COUNT < 1 || PIN_COUNT > (1 << edge_event_pkg::SEL_W)) begin : g_bad_pins
    $error("pin count out of range for selector width");
  end
  if (ADDR_W < 8) begin : g_bad_addr
    $error("address width too small for register map");
  end

  function automatic logic pick_pin(input logic [PIN_COUNT-1:0] p,
                                    input logic [edge_event_pkg::SEL_W-1:0] s);
    pick_pin = (int'(s) < PIN_COUNT) ? p[s] : 1'b0;
  endfunction

  function automatic logic [7:0] word_ofs(input logic [ADDR_W-1:0] a);
    word_ofs = {a[7:2], 2'b00};
  endfunction

  // =========================================================
  // state
  logic [N-1:0]                      imask_q;
  logic [N-1:0]                      emask_q;
  logic [N-1:0]                      rise_q;
  logic [N-1:0]                      fall_q;
  logic [N-1:0]                      pend_q;
  logic [N-1:0]                      pend_d;
  logic [N-1:0]                      prev_q;
  logic                              primed_q;
  logic [edge_event_pkg::SEL_W-1:0]  sel_q [edge_event_pkg::EXT_LINES];
  logic [N-1:0]                      cur_line;
  logic [N-1:0]                      hit;
  logic [N-1:0]                      sw_set;
  logic [N-1:0]                      clr;
  logic                              wr;
  logic                              mapped;
  logic [7:0]                        ofs;
  logic [31:0]                       rd_d;

  // =========================================================
  // apb decode
  assign ofs    = word_ofs(paddr);
  assign mapped = (paddr[1:0] == 2'b00) && ((paddr >> 8) == '0) &&
                  (ofs <= edge_event_pkg::OFS_SEL3);
  assign wr      = psel && penable && pwrite && mapped;
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    rd_d = 32'h0000_0000;
    if (mapped) begin
      unique case (ofs)
        edge_event_pkg::OFS_INT_MASK: rd_d[N-1:0] = imask_q;
        edge_event_pkg::OFS_EVT_MASK: rd_d[N-1:0] = emask_q;
        edge_event_pkg::OFS_RISE_EN:  rd_d[N-1:0] = rise_q;
        edge_event_pkg::OFS_FALL_EN:  rd_d[N-1:0] = fall_q;
        edge_event_pkg::OFS_PENDING:  rd_d[N-1:0] = pend_q;
        default: begin
          for (int r = 0; r < edge_event_pkg::SEL_REGS; r++) begin
            if (ofs == 8'(edge_event_pkg::OFS_SEL0 + 8'(4 * r))) begin
              for (int k = 0; k < edge_event_pkg::SEL_PER_REG; k++) begin
                rd_d[k*edge_event_pkg::SEL_SLOT +: edge_event_pkg::SEL_W] =
                  sel_q[r*edge_event_pkg::SEL_PER_REG + k];
              end
            end
          end
        end
      endcase
    end
  end

  // read data latched in the setup cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_d;
    end
  end

  // =========================================================
  // configuration registers
  always_ff @(posedge clock) begin
    if (rst) begin
      imask_q <= edge_event_pkg::RST_MASK;
      emask_q <= edge_event_pkg::RST_MASK;
    end else if (wr && ofs == edge_event_pkg::OFS_INT_MASK) begin
      imask_q <= pwdata[N-1:0];
    end else if (wr && ofs == edge_event_pkg::OFS_EVT_MASK) begin
      emask_q <= pwdata[N-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rise_q <= edge_event_pkg::RST_EDGE;
      fall_q <= edge_event_pkg::RST_EDGE;
    end else if (wr && ofs == edge_event_pkg::OFS_RISE_EN) begin
      rise_q <= pwdata[N-1:0];
    end else if (wr && ofs == edge_event_pkg::OFS_FALL_EN) begin
      fall_q <= pwdata[N-1:0];
    end
  end

  // pin selectors, one field per external line
  for (genvar g = 0; g < edge_event_pkg::EXT_LINES; g++) begin : g_sel
    localparam int REG  = g / edge_event_pkg::SEL_PER_REG;
    localparam int SLOT = g % edge_event_pkg::SEL_PER_REG;
    always_ff @(posedge clock) begin
      if (rst) begin
        sel_q[g] <= edge_event_pkg::RST_SEL;
      end else if (wr && ofs == 8'(edge_event_pkg::OFS_SEL0 + 8'(4 * REG))) begin
        sel_q[g] <= pwdata[SLOT*edge_event_pkg::SEL_SLOT +: edge_event_pkg::SEL_W];
      end
    end
    assign cur_line[g] = pick_pin(gpio_in, sel_q[g]);
  end
  assign cur_line[N-1:edge_event_pkg::EXT_LINES] = int_src;

  // =========================================================
  // edge detection
  always_ff @(posedge clock) begin
    if (rst) begin
      prev_q   <= '0;
      primed_q <= 1'b0;
    end else begin
      prev_q   <= cur_line;
      primed_q <= 1'b1;
    end
  end

  // every sample is compared, so a single-sample pulse yields both edges
  assign hit = primed_q ? ((cur_line & ~prev_q & rise_q) |
                           (~cur_line & prev_q & fall_q)) : '0;

  assign sw_set = (wr && ofs == edge_event_pkg::OFS_SW_TRIG) ? pwdata[N-1:0] : '0;
  assign clr    = (wr && ofs == edge_event_pkg::OFS_PENDING) ? pwdata[N-1:0] : '0;

  // =========================================================
  // pending bits, set wins over clear
  assign pend_d = (pend_q & ~clr) | ((hit | sw_set) & imask_q);

  always_ff @(posedge clock) begin
    if (rst) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // event pulses
  always_ff @(posedge clock) begin
    if (rst) begin
      line_event <= '0;
    end else begin
      line_event <= (hit | sw_set) & emask_q;
    end
  end

  assign line_irq = pend_q & imask_q;
  assign irq      = |line_irq;

  // =========================================================
  // checks
  AST_RISE_SETS_PENDING: assert property (@(posedge clock) disable iff (rst)
    (primed_q && cur_line[0] && !prev_q[0] && rise_q[0] && imask_q[0])
      |=> pend_q[0] && irq)
    else $error("rising edge did not set pending");

  AST_FALL_ONLY_IGNORES_RISE: assert property (@(posedge clock) disable iff (rst)
    (cur_line[1] && !prev_q[1] && !rise_q[1] && !sw_set[1] && !pend_q[1])
      |=> !pend_q[1])
    else $error("rising edge set pending with rise disabled");

  AST_MASKED_LINE_SILENT: assert property (@(posedge clock) disable iff (rst)
    (hit[2] && !imask_q[2] && !emask_q[2] && !pend_q[2])
      |=> !pend_q[2] && !line_event[2])
    else $error("masked line forwarded a request");

  AST_EVENT_PULSE: assert property (@(posedge clock) disable iff (rst)
    ((hit[2] || sw_set[2]) && emask_q[2]) ##1 (!hit[2] && !sw_set[2])
      |-> line_event[2] ##1 !line_event[2])
    else $error("event pulse missing or stretched");

  AST_NARROW_PULSE: assert property (@(posedge clock) disable iff (rst)
    (primed_q && !prev_q[1] && cur_line[1] && fall_q[1] && !rise_q[1] && imask_q[1])
      ##1 (!cur_line[1] && $stable(fall_q[1]) && $stable(imask_q[1]) && clr[1] == 1'b0)
      |=> pend_q[1])
    else $error("single-sample pulse not captured");

  AST_SELECTOR_ROUTES: assert property (@(posedge clock) disable iff (rst)
    (primed_q && int'(sel_q[0]) < PIN_COUNT && $stable(sel_q[0]) &&
     $rose(gpio_in[sel_q[0]]) && rise_q[0] && imask_q[0]) |=> pend_q[0])
    else $error("selected pin did not reach its line");

  AST_ZERO_WRITE_KEEPS: assert property (@(posedge clock) disable iff (rst)
    (pend_q[1] && !(wr && ofs == edge_event_pkg::OFS_PENDING && pwdata[1])) |=> pend_q[1])
    else $error("pending bit lost without a one written");

  AST_ONE_WRITE_CLEARS: assert property (@(posedge clock) disable iff (rst)
    (wr && ofs == edge_event_pkg::OFS_PENDING && pwdata[0] && !hit[0] && !sw_set[0])
      |=> !pend_q[0])
    else $error("pending bit not cleared by a one");
endmodule

// ### pin_model.sv
// pin and internal source model facing the edge event unit
`timescale 1ns/1ns

module pin_model (
  input  wire logic         clock,
  output logic      [111:0] gpio,
  output logic      [1:0]   src
);
  // =========================================================
  // idle levels
  initial begin
    gpio = '0;
    src  = '0;
  end

  // =========================================================
  // stimulus tasks
  // one-sample pulse, the narrowest the unit sees
  task pulse(input int p);
    @(posedge clock) gpio[p] <= 1'b1;
    @(posedge clock) gpio[p] <= 1'b0;
  endtask

  // level change on an internal source line
  task toggle_src(input int n);
    @(posedge clock) src[n] <= ~src[n];
  endtask
endmodule

// ### tb.sv
// self-checking testbench for the edge event request unit
`timescale 1ns/1ns

module tb;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [111:0] gpio_in;
  logic [1:0]  int_src;
  logic [17:0] line_irq, line_event;
  logic [32:0] exp_q[$];
  logic [6:0]  p;
  int          miscompares, n_compared, cycles, ev_count;

  edge_event_request_unit i_edge_event_request_unit (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_in(gpio_in), .int_src(int_src),
    .line_irq(line_irq), .line_event(line_event), .irq(irq));
  pin_model i_pin_model (.clock(clock), .gpio(gpio_in), .src(int_src));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // =========================================================
  // shared tasks
  task cmp(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task stop_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one apb transfer; e holds {pslverr, prdata} expected at completion
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    @(posedge clock) penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // =========================================================
  // monitor: completions, event pulses, timeout
  always @(posedge clock) begin
    cycles++;
    if (cycles > 3000) begin
      miscompares++;
      stop_test();
    end
    ev_count += $countones(line_event);
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      cmp({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // =========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    miscompares = 0;
    n_compared = 0;
    cycles = 0;
    ev_count = 0;
    void'($urandom(32'h6c93));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) apb(1'b0, 8'(4 * i), '0, 33'h0);
    apb(1'b0, 8'h28, '0, 33'h1_0000_0000);
    apb(1'b1, 8'h2c, 32'hffff_ffff, 33'h1_0000_0000);
    p = 7'($urandom_range(111, 0));
    apb(1'b1, edge_event_pkg::OFS_SEL0, {9'h0, p, 1'b0, p, 1'b0, p}, 33'h0);
    apb(1'b1, edge_event_pkg::OFS_INT_MASK, 32'h10003, 33'h0);
    apb(1'b1, edge_event_pkg::OFS_EVT_MASK, 32'h4, 33'h0);
    apb(1'b1, edge_event_pkg::OFS_RISE_EN, 32'h10005, 33'h0);
    apb(1'b1, edge_event_pkg::OFS_FALL_EN, 32'h10002, 33'h0);
    apb(1'b0, edge_event_pkg::OFS_INT_MASK, '0, 33'h10003);
    i_pin_model.pulse(p);
    repeat (3) @(posedge clock);
    cmp(33'(line_irq), 33'h3);
    cmp(33'(irq), 33'h1);
    cmp(33'(ev_count), 33'h1);
    apb(1'b0, edge_event_pkg::OFS_PENDING, '0, 33'h3);
    apb(1'b1, edge_event_pkg::OFS_PENDING, 32'h0, 33'h0);
    apb(1'b0, edge_event_pkg::OFS_PENDING, '0, 33'h3);
    apb(1'b1, edge_event_pkg::OFS_PENDING, 32'h1, 33'h0);
    apb(1'b0, edge_event_pkg::OFS_PENDING, '0, 33'h2);
    apb(1'b1, edge_event_pkg::OFS_PENDING, 32'h2, 33'h0);
    @(posedge clock);
    cmp(33'(irq), 33'h0);
    for (int k = 0; k < 2; k++) begin
      i_pin_model.toggle_src(0);
      repeat (3) @(posedge clock);
      cmp(33'(line_irq), 33'h10000);
      apb(1'b1, edge_event_pkg::OFS_PENDING, 32'h10000, 33'h0);
    end
    apb(1'b1, edge_event_pkg::OFS_SW_TRIG, 32'h5, 33'h0);
    repeat (2) @(posedge clock);
    cmp(33'(ev_count), 33'h2);
    apb(1'b0, edge_event_pkg::OFS_PENDING, '0, 33'h1);
    apb(1'b1, edge_event_pkg::OFS_EVT_MASK, 32'h0, 33'h0);
    i_pin_model.pulse(p);
    repeat (3) @(posedge clock);
    cmp(33'(ev_count), 33'h2);
    cmp(33'(line_irq), 33'h3);
    repeat (2) @(posedge clock);
    stop_test();
  end
endmodule
